// ### hw/ceau_pkg.sv
package ceau_pkg;
   // ----------------------------------------------------------------
   // Addressing modes
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      IMPLIED_OPERAND_MODE,
      LITERAL_OPERAND_MODE,
      PAGE_ZERO_MODE,
      LONG_ADDRESS_MODE,
      POINTER_ONLY_MODE,
      POINTER_BYTE_OFFSET_MODE,
      POINTER_WORD_OFFSET_MODE,
      BRANCH_OFFSET_MODE,
      BIT_MODIFY_MODE,
      BIT_BRANCH_MODE
   } ceau_mode_e;

   // ----------------------------------------------------------------
   // Constants
   // ----------------------------------------------------------------
   localparam logic [15:0] CEAU_PC_RESET = 16'h0000;
   localparam logic [15:0] CEAU_LEN_1 = 16'h0001;
   localparam logic [15:0] CEAU_LEN_2 = 16'h0002;
   localparam logic [15:0] CEAU_LEN_3 = 16'h0003;
   localparam logic [7:0] CEAU_PAGE_ZERO = 8'h00;
   localparam int CEAU_BIT_MODIFY_LSB = 1;
   localparam int CEAU_BIT_BRANCH_LSB = 1;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      ceau_mode_e mode;
      logic [7:0] opcode;
      logic [7:0] byte1;
      logic [7:0] byte2;
      logic [7:0] index;
      logic cond_true;
   } ceau_req_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] next_pc;
      logic [2:0] bit_sel;
      logic addr_valid;
   } ceau_res_s;
endpackage : ceau_pkg

// ### hw/ceau_adder.sv
`timescale 1ns/1ps
`default_nettype none
module ceau_adder (
   input wire logic [15:0] a_i,
   input wire logic [15:0] b_i,
   output logic [15:0] sum_o
);
   // Carry out of bit 15 is dropped on purpose
   assign sum_o = a_i + b_i;
endmodule : ceau_adder
`default_nettype wire

// ### hw/ceau_top.sv
`timescale 1ns/1ps
`default_nettype none
module ceau_top (
   input wire logic CLK_I,
   input wire logic RESETN_I,
   input wire logic STEP_I,
   input wire ceau_pkg::ceau_req_s REQ_I,
   output ceau_pkg::ceau_res_s RES_O,
   output logic [15:0] PC_O
);
   import ceau_pkg::*;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Sign-extends a branch displacement byte to the address width
   function automatic logic [15:0] sext8(input logic [7:0] b);
      sext8 = {{8{b[7]}}, b};
   endfunction : sext8

   // Builds an address inside the lowest page of memory
   function automatic logic [15:0] page_addr(input logic [7:0] lo);
      page_addr = {CEAU_PAGE_ZERO, lo};
   endfunction : page_addr

   // Nine-bit sum of the index and one offset byte; bit 8 is the carry
   function automatic logic [8:0] idx_add(
      input logic [7:0] idx,
      input logic [7:0] off
   );
      idx_add = {1'b0, idx} + {1'b0, off};
   endfunction : idx_add

   // True for the modes whose instruction is three bytes long
   function automatic logic is_long(input ceau_mode_e m);
      is_long = (m == LONG_ADDRESS_MODE) ||
                (m == POINTER_WORD_OFFSET_MODE) ||
                (m == BIT_BRANCH_MODE);
   endfunction : is_long

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   logic mode_implied;
   logic mode_pointer_only;
   logic mode_branch;
   logic mode_bit_branch;
   logic mode_three_bytes;
   logic mode_one_byte;
   logic mode_legal;

   assign mode_implied = (REQ_I.mode == IMPLIED_OPERAND_MODE);
   assign mode_pointer_only = (REQ_I.mode == POINTER_ONLY_MODE);
   assign mode_branch = (REQ_I.mode == BRANCH_OFFSET_MODE);
   assign mode_bit_branch = (REQ_I.mode == BIT_BRANCH_MODE);
   assign mode_three_bytes = is_long(REQ_I.mode);
   assign mode_one_byte = mode_implied || mode_pointer_only;
   // Codes past the last mode are illegal and must not move the counter
   assign mode_legal = (REQ_I.mode <= BIT_BRANCH_MODE);

   // ----------------------------------------------------------------
   // Instruction length
   // ----------------------------------------------------------------
   logic [15:0] len;

   // Every mode not named here is two bytes long
   assign len = mode_one_byte ? CEAU_LEN_1 :
                mode_three_bytes ? CEAU_LEN_3 :
                CEAU_LEN_2;

   // ----------------------------------------------------------------
   // Indexed sums
   // ----------------------------------------------------------------
   logic [8:0] idx_sum1;
   logic [8:0] idx_sum2;
   logic [7:0] word_high;
   logic [15:0] operand_word;

   assign idx_sum1 = idx_add(REQ_I.index, REQ_I.byte1);
   assign idx_sum2 = idx_add(REQ_I.index, REQ_I.byte2);
   // The carry into the high byte may wrap past the top of memory
   assign word_high = REQ_I.byte1 + {7'h00, idx_sum2[8]};
   assign operand_word = {word_high, idx_sum2[7:0]};

   // ----------------------------------------------------------------
   // Bit select
   // ----------------------------------------------------------------
   logic [2:0] modify_bit;
   logic [2:0] test_bit;

   // Opcode bit 0 picks set/clear or the sense, so the field sits above it
   assign modify_bit = REQ_I.opcode[CEAU_BIT_MODIFY_LSB +: 3];
   assign test_bit = REQ_I.opcode[CEAU_BIT_BRANCH_LSB +: 3];

   // ----------------------------------------------------------------
   // Program counter arithmetic
   // ----------------------------------------------------------------
   logic [15:0] pc_ff;
   logic [15:0] seq_pc;
   logic [15:0] branch_off;
   logic [15:0] branch_target;
   logic [15:0] lit_addr;
   logic taken;
   logic [15:0] step_pc;
   logic [15:0] nxt_pc;

   // All three adders share one wrap-around rule so no carry leaks past bit 15
   ceau_adder u_seq (
      .a_i(pc_ff),
      .b_i(len),
      .sum_o(seq_pc)
   );
   ceau_adder u_branch (
      .a_i(seq_pc),
      .b_i(branch_off),
      .sum_o(branch_target)
   );
   ceau_adder u_lit (
      .a_i(pc_ff),
      .b_i(CEAU_LEN_1),
      .sum_o(lit_addr)
   );

   // The displacement sits in byte two for bit branches, else byte one
   assign branch_off = mode_bit_branch ? sext8(REQ_I.byte2) :
                       sext8(REQ_I.byte1);
   assign taken = REQ_I.cond_true &&
                  (mode_branch || mode_bit_branch);
   // The target is measured from the end of the instruction
   assign step_pc = !mode_legal ? pc_ff :
                    taken ? branch_target :
                    seq_pc;
   // Without a step the counter simply recirculates
   assign nxt_pc = STEP_I ? step_pc : pc_ff;

   // ----------------------------------------------------------------
   // Result assembly
   // ----------------------------------------------------------------
   ceau_res_s step_res;
   ceau_res_s res_ff;
   ceau_res_s nxt_res;

   always_comb begin
      step_res = '0;
      step_res.next_pc = step_pc;
      step_res.addr_valid = 1'b1;
      unique case (REQ_I.mode)
         IMPLIED_OPERAND_MODE: begin
            step_res.addr_valid = 1'b0;
         end

         LITERAL_OPERAND_MODE: begin
            step_res.addr = lit_addr;
         end

         PAGE_ZERO_MODE: begin
            step_res.addr = page_addr(REQ_I.byte1);
         end

         LONG_ADDRESS_MODE: begin
            step_res.addr = {REQ_I.byte1, REQ_I.byte2};
         end

         POINTER_ONLY_MODE: begin
            step_res.addr = page_addr(REQ_I.index);
         end

         POINTER_BYTE_OFFSET_MODE: begin
            step_res.addr = {7'h00, idx_sum1};
         end

         POINTER_WORD_OFFSET_MODE: begin
            step_res.addr = operand_word;
         end

         BRANCH_OFFSET_MODE: begin
            step_res.addr_valid = 1'b0;
         end

         BIT_MODIFY_MODE: begin
            step_res.addr = page_addr(REQ_I.byte1);
            step_res.bit_sel = modify_bit;
         end

         BIT_BRANCH_MODE: begin
            step_res.addr = page_addr(REQ_I.byte1);
            step_res.bit_sel = test_bit;
         end

         default: begin
            // Illegal codes report no operand and keep the counter
            step_res.addr_valid = 1'b0;
         end
      endcase
   end

   // A result stands until the next accepted step
   assign nxt_res = STEP_I ? step_res : res_ff;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Index is only read here, never written, so it stays untouched
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         pc_ff <= CEAU_PC_RESET;
         res_ff <= '0;
      end else begin
         pc_ff <= nxt_pc;
         res_ff <= nxt_res;
      end
   end

   // Outputs come straight from the registers
   assign RES_O = res_ff;
   assign PC_O = pc_ff;
endmodule : ceau_top
`default_nettype wire

// ### bench/ceau_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ceau_mem (
   input wire logic [15:0] a_i,
   output logic [7:0] d_o
);
   // Program bytes are a fixed pattern, so fetch has no wait states
   assign d_o = a_i[7:0] ^ a_i[15:8] ^ 8'hA5;
endmodule : ceau_mem
`default_nettype wire

// ### bench/ceau_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ceau_properties (
   input wire logic CLK_I,
   input wire logic RESETN_I,
   input wire logic STEP_I,
   input wire ceau_pkg::ceau_req_s REQ_I,
   input wire ceau_pkg::ceau_res_s RES_O,
   input wire logic [15:0] PC_O
);
   import ceau_pkg::*;
   ceau_req_s q_ff;
   logic [15:0] p_ff;
   // Copies of the taken request keep each check short
   always_ff @(posedge CLK_I) begin
      q_ff <= REQ_I;
      p_ff <= PC_O;
   end
   wire logic [15:0] s1_w = {{8{q_ff.byte1[7]}}, q_ff.byte1};
   wire logic [15:0] s2_w = {{8{q_ff.byte2[7]}}, q_ff.byte2};
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);
   sequence go(ceau_mode_e k);
      STEP_I && REQ_I.mode == k;
   endsequence
   a_implied_op: assert property (go(IMPLIED_OPERAND_MODE) |=>
      !RES_O.addr_valid && PC_O == p_ff + 16'h1) else $error("imp");
   a_bit_modify: assert property (go(BIT_MODIFY_MODE) |=>
      RES_O.addr == {8'h00, q_ff.byte1} && RES_O.bit_sel == q_ff.opcode[3:1]
      && PC_O == p_ff + 16'h2) else $error("bm");
   a_next_pc: assert property (STEP_I |=>
      RES_O.next_pc == PC_O) else $error("npc");
   a_idle_hold: assert property (!STEP_I |=>
      $stable(PC_O) && $stable(RES_O)) else $error("hold");
   a_lit_addr: assert property (go(LITERAL_OPERAND_MODE) |=>
      RES_O.addr == p_ff + 16'h1 && PC_O == p_ff + 16'h2) else $error("lit");
   a_page_zero: assert property (go(PAGE_ZERO_MODE) |=>
      RES_O.addr == {8'h00, q_ff.byte1}) else $error("pz");
   a_long_addr: assert property (go(LONG_ADDRESS_MODE) |=>
      RES_O.addr == {q_ff.byte1, q_ff.byte2} && PC_O == p_ff + 16'h3)
      else $error("long");
   a_ptr_only: assert property (go(POINTER_ONLY_MODE) |=>
      RES_O.addr == {8'h00, q_ff.index} && PC_O == p_ff + 16'h1)
      else $error("ptr");
   a_byte_off: assert property (go(POINTER_BYTE_OFFSET_MODE) |=>
      RES_O.addr == {8'h00, q_ff.index} + q_ff.byte1 && PC_O == p_ff + 16'h2)
      else $error("bo");
   a_word_off: assert property (go(POINTER_WORD_OFFSET_MODE) |=>
      RES_O.addr == {q_ff.byte1, q_ff.byte2} + q_ff.index
      && PC_O == p_ff + 16'h3) else $error("wo");
   a_branch_pc: assert property (go(BRANCH_OFFSET_MODE) |=>
      PC_O == p_ff + 16'h2 + (q_ff.cond_true ? s1_w : 16'h0)) else $error("br");
   a_bit_branch: assert property (go(BIT_BRANCH_MODE) |=>
      RES_O.addr == {8'h00, q_ff.byte1} && RES_O.bit_sel == q_ff.opcode[3:1]
      && PC_O == p_ff + 16'h3 + (q_ff.cond_true ? s2_w : 16'h0))
      else $error("bb");
   c_taken: cover property (go(BRANCH_OFFSET_MODE) ##0 REQ_I.cond_true);
   c_b2b: cover property (STEP_I [*2]);
   c_idle: cover property (!STEP_I [*2]);
endmodule : ceau_properties
bind ceau_top ceau_properties chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
   .STEP_I(STEP_I), .REQ_I(REQ_I), .RES_O(RES_O), .PC_O(PC_O));
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ceau_pkg::*;
   logic CLK_I = 1'b0;
   logic RESETN_I = 1'b0;
   logic STEP_I = 1'b0;
   ceau_req_s rq = '0;
   ceau_req_s req;
   ceau_res_s RES_O;
   logic [15:0] PC_O;
   logic [7:0] b1;
   logic [7:0] b2;
   logic v;
   int num_errors = 0;
   int tests_run = 0;
   // Operand bytes follow the PC, as a real fetch would
   assign req = {rq.mode, rq.opcode, b1, b2, rq.index, rq.cond_true};
   ceau_top uut (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .STEP_I(STEP_I),
      .REQ_I(req), .RES_O(RES_O), .PC_O(PC_O));
   ceau_mem m1 (.a_i(PC_O + 16'h1), .d_o(b1));
   ceau_mem m2 (.a_i(PC_O + 16'h2), .d_o(b2));
   always #25 CLK_I = ~CLK_I;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %h vs %h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   // Taken backward branch from zero must wrap: byte at 1 is A4
   task automatic t_wrap;
      STEP_I <= 1'b1;
      rq <= {BRANCH_OFFSET_MODE, 33'h1};
      @(posedge CLK_I);
      STEP_I <= 1'b0;
      @(negedge CLK_I);
      chk(PC_O, 16'hFFA6);
      chk(RES_O.next_pc, 16'hFFA6);
      chk(RES_O.addr, 16'h0000);
      @(posedge CLK_I);
   endtask : t_wrap
   // Every mode back to back, branch not taken then taken
   task automatic t_modes;
      for (int i = 0; i <= 20; i++) begin
         STEP_I <= (i < 20);
         rq <= {4'(i % 10), 8'(8'hF6 + i), 16'h0, 8'(8'hF6 + i), 1'(i / 10)};
         @(negedge CLK_I);
         if (i > 0) chk({15'h0, RES_O.addr_valid}, {15'h0, v});
         v = !((i % 10) inside {0, 7});
         @(posedge CLK_I);
      end
   endtask : t_modes
   initial begin
      repeat (5) @(posedge CLK_I);
      RESETN_I <= 1'b1;
      t_wrap();
      t_modes();
      report_and_stop();
   end
   initial begin
      #20000;
      num_errors++;
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
